// file: verilog/sspa_pkg.sv
/*
  Shared constants and the link state type of the serial-bus target
  with alert signalling.
  Assumes it is compiled before every module that imports it.
*/
package sspa_pkg;

  localparam int          BYTE_W    = 8;
  localparam int          ADDR_W    = 7;
  localparam int          BIT_CNT_W = 3;
  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam logic [2:0]  BIT_FIRST = 3'h0;
  // Broadcast address that the host reads to find who pulls alert.
  localparam logic [6:0]  ARA_ADDR  = 7'h0c;
  // Eighth bit of the alert response byte; either level is allowed.
  localparam logic        ARA_LSB   = 1'b0;
  localparam logic        RW_READ   = 1'b1;
  // Status bits that never reach the alert output.
  localparam logic [7:0]  NOALERT_BYTE_MASK = 8'h40;
  localparam logic [7:0]  NOALERT_HI_MASK   = 8'h08;
  localparam logic [7:0]  IDX_CMD   = 8'h00;
  localparam logic [7:0]  IDX_FIRST = 8'h01;
  localparam logic [7:0]  IDX_STEP  = 8'h01;

  // Gray sequence along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_WR       = 3'b010,
    ST_WR_ACK   = 3'b110,
    ST_RD       = 3'b111,
    ST_RD_ACK   = 3'b101,
    ST_WAIT     = 3'b100
  } sspa_state_t;

endpackage

// file: verilog/sspa_sync.sv
/*
  Two-flip-flop level synchroniser of parameterised width.
  Assumes each bit is a level that is stable for several destination clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sspa_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);
  logic [W-1:0] meta_reg;

  // The first stage feeds the second stage only.
  always_ff @(posedge i_clk) begin
    meta_reg <= i_d;
    o_q      <= meta_reg;
  end
endmodule
`default_nettype wire

// file: verilog/sspa_evt_xing.sv
/*
  Single-cycle event crossing by toggle and two-stage synchroniser.
  Assumes events are spaced by more than four destination clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sspa_evt_xing (
  input  wire logic i_src_clk,
  input  wire logic i_src_rst_n,
  input  wire logic i_pulse,
  input  wire logic i_dst_clk,
  input  wire logic i_dst_rst_n,
  output var  logic o_pulse
);
  logic tgl_reg;
  logic tgl_s;
  logic last_reg;

  always_ff @(posedge i_src_clk) begin
    if (!i_src_rst_n) begin
      tgl_reg <= 1'b0;
    end else if (i_pulse) begin
      tgl_reg <= ~tgl_reg;
    end
  end

  sspa_sync #(.W(1)) u_sync (
    .i_clk (i_dst_clk),
    .i_d   (tgl_reg),
    .o_q   (tgl_s)
  );

  always_ff @(posedge i_dst_clk) begin
    if (!i_dst_rst_n) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= tgl_s;
    end
  end

  assign o_pulse = tgl_s ^ last_reg;
endmodule
`default_nettype wire

// file: verilog/sspa_top.sv
/*
  Serial-bus target framing, acknowledge duties and alert signalling.
  The bus engine runs on the link clock; the user side runs on the
  reference clock. Assumes SCL and SDA change slowly against the link
  clock (a half period of at least 16 link clocks).
*/
// Behaviour
// - Start, address, write bit, target acknowledges.
// - Send byte: command only, acknowledged, then stop.
// - Completed send byte clears fault status.
// - Repeated start after command allows a read.
// - Write byte: command and data, each acknowledged.
// - Write word: all three bytes acknowledged.
// - Block write: command, count, data all acknowledged.
// - Read byte: read address acknowledged, byte returned.
// - Read word returns low byte then high.
// - Block read sends count then data bytes.
// - Alert is open drain, never driven high.
// - Alert low while an unmasked status bit set.
// - Target answers the alert response address.
// - Masked bits and two fixed bits ignored.
// - Alert response only while pulling alert; returns address.
`timescale 1ns/1ps
`default_nettype none
module sspa_top #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  input  wire logic                         I_REF_CLK,
  input  wire logic                         I_RESET_N,
  input  wire logic                         I_LINK_CLK,
  input  wire logic                         I_SCL,
  input  wire logic                         I_SDA,
  output var  logic                         O_SDA,
  output var  logic                         O_SDA_OE_N,
  output var  logic                         O_ALERT,
  output var  logic                         O_ALERT_OE_N,
  input  wire logic [sspa_pkg::BYTE_W-1:0]  I_STATUS_BYTE,
  input  wire logic [sspa_pkg::BYTE_W-1:0]  I_STATUS_WORD_HI,
  input  wire logic [sspa_pkg::BYTE_W-1:0]  I_MASK_BYTE,
  input  wire logic [sspa_pkg::BYTE_W-1:0]  I_MASK_WORD_HI,
  output var  logic [sspa_pkg::BYTE_W-1:0]  O_CMD,
  output var  logic                         O_CMD_VALID,
  output var  logic [sspa_pkg::BYTE_W-1:0]  O_WR_DATA,
  output var  logic [sspa_pkg::BYTE_W-1:0]  O_WR_INDEX,
  output var  logic                         O_WR_VALID,
  output var  logic                         O_CLEAR_FAULTS,
  output var  logic [sspa_pkg::BYTE_W-1:0]  O_RD_INDEX,
  output var  logic                         O_RD_REQ,
  input  wire logic [sspa_pkg::BYTE_W-1:0]  I_RD_DATA
);
  import sspa_pkg::*;

  if (DEV_ADDR == ARA_ADDR) begin : g_bad_addr
    $error("DEV_ADDR must differ from the alert response address");
  end

  // Link-domain signals.
  logic                 link_rst_n;
  logic                 scl_s;
  logic                 sda_s;
  logic                 alert_l;
  logic                 scl_d_reg;
  logic                 sda_d_reg;
  logic                 start_c;
  logic                 stop_c;
  logic                 rise_c;
  logic                 fall_c;
  sspa_state_t          state_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic                 got_byte_reg;
  logic [BYTE_W-1:0]    shift_reg;
  logic                 sda_low_reg;
  logic                 is_read_reg;
  logic                 is_write_reg;
  logic                 ara_reg;
  logic [BYTE_W-1:0]    wr_idx_reg;
  logic [BYTE_W-1:0]    rd_idx_reg;
  logic [BYTE_W-1:0]    wdata_l_reg;
  logic [BYTE_W-1:0]    widx_l_reg;
  logic [BYTE_W-1:0]    rd_buf_reg;
  logic [BYTE_W-1:0]    tx_byte;
  logic                 addr_hit;
  logic                 ara_hit;
  logic                 cmd_ev_reg;
  logic                 wr_ev_reg;
  logic                 rd_ev_reg;
  logic                 clr_ev_reg;
  logic                 rd_ack_l;

  // Reference-domain signals.
  logic                 cmd_r;
  logic                 wr_r;
  logic                 rd_r;
  logic                 clr_r;
  logic                 alert_reg;
  logic [BYTE_W-1:0]    rd_data_reg;
  logic                 rd_ack_reg;
  logic [BYTE_W-1:0]    alert_byte;
  logic [BYTE_W-1:0]    alert_hi;

  // Reset reaches the link domain through a synchroniser; the link
  // clock must run while reset is held.
  sspa_sync #(.W(1)) u_rst_sync (
    .i_clk (I_LINK_CLK),
    .i_d   (I_RESET_N),
    .o_q   (link_rst_n)
  );

  sspa_sync #(.W(2)) u_pin_sync (
    .i_clk (I_LINK_CLK),
    .i_d   ({I_SCL, I_SDA}),
    .o_q   ({scl_s, sda_s})
  );

  sspa_sync #(.W(1)) u_alert_sync (
    .i_clk (I_LINK_CLK),
    .i_d   (alert_reg),
    .o_q   (alert_l)
  );

  always_ff @(posedge I_LINK_CLK) begin
    if (!link_rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_c  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign rise_c  = scl_s & ~scl_d_reg;
  assign fall_c  = ~scl_s & scl_d_reg;

  assign addr_hit = (shift_reg[BYTE_W-1:1] == DEV_ADDR);
  // Only a target that is pulling alert answers the broadcast read.
  assign ara_hit  = (shift_reg[BYTE_W-1:1] == ARA_ADDR) && (shift_reg[0] == RW_READ)
                    && alert_l;
  assign tx_byte  = ara_reg ? {DEV_ADDR, ARA_LSB} : rd_buf_reg;

  // Bus state machine.
  always_ff @(posedge I_LINK_CLK) begin
    if (!link_rst_n) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= BIT_FIRST;
      got_byte_reg <= 1'b0;
      shift_reg    <= '0;
      sda_low_reg  <= 1'b0;
      is_read_reg  <= 1'b0;
      ara_reg      <= 1'b0;
    end else if (stop_c) begin
      state_reg    <= ST_IDLE;
      sda_low_reg  <= 1'b0;
      got_byte_reg <= 1'b0;
    end else if (start_c) begin
      state_reg    <= ST_ADDR;
      bit_cnt_reg  <= BIT_FIRST;
      got_byte_reg <= 1'b0;
      sda_low_reg  <= 1'b0;
      ara_reg      <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WR: begin
          if (rise_c) begin
            shift_reg    <= {shift_reg[BYTE_W-2:0], sda_s};
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            got_byte_reg <= (bit_cnt_reg == BIT_LAST);
          end else if (fall_c && got_byte_reg) begin
            got_byte_reg <= 1'b0;
            if (state_reg == ST_WR) begin
              state_reg   <= ST_WR_ACK;
              sda_low_reg <= 1'b1;
            end else if (addr_hit || ara_hit) begin
              state_reg   <= ST_ADDR_ACK;
              sda_low_reg <= 1'b1;
              is_read_reg <= shift_reg[0];
              ara_reg     <= ara_hit;
            end else begin
              state_reg   <= ST_WAIT;
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (fall_c) begin
            bit_cnt_reg <= BIT_FIRST;
            if ((state_reg == ST_ADDR_ACK) && is_read_reg) begin
              state_reg   <= ST_RD;
              shift_reg   <= {tx_byte[BYTE_W-2:0], 1'b0};
              sda_low_reg <= ~tx_byte[BYTE_W-1];
            end else begin
              state_reg   <= ST_WR;
              sda_low_reg <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (rise_c) begin
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            got_byte_reg <= (bit_cnt_reg == BIT_LAST);
          end else if (fall_c) begin
            if (got_byte_reg) begin
              got_byte_reg <= 1'b0;
              state_reg    <= ST_RD_ACK;
              sda_low_reg  <= 1'b0;
            end else begin
              shift_reg   <= {shift_reg[BYTE_W-2:0], 1'b0};
              sda_low_reg <= ~shift_reg[BYTE_W-1];
            end
          end
        end
        ST_RD_ACK: begin
          if (rise_c && (sda_s || ara_reg)) begin
            state_reg <= ST_WAIT;
          end else if (fall_c) begin
            // Host acknowledged: send the next byte of the word or block.
            state_reg   <= ST_RD;
            bit_cnt_reg <= BIT_FIRST;
            shift_reg   <= {tx_byte[BYTE_W-2:0], 1'b0};
            sda_low_reg <= ~tx_byte[BYTE_W-1];
          end
        end
        ST_WAIT, ST_IDLE: begin
          sda_low_reg <= 1'b0;
        end
        default: begin
          state_reg   <= ST_IDLE;
          sda_low_reg <= 1'b0;
        end
      endcase
    end
  end

  // Write-side byte bookkeeping and events towards the user side.
  always_ff @(posedge I_LINK_CLK) begin
    if (!link_rst_n) begin
      is_write_reg <= 1'b0;
      wr_idx_reg   <= IDX_CMD;
      wdata_l_reg  <= '0;
      widx_l_reg   <= IDX_CMD;
      cmd_ev_reg   <= 1'b0;
      wr_ev_reg    <= 1'b0;
      clr_ev_reg   <= 1'b0;
    end else begin
      cmd_ev_reg <= 1'b0;
      wr_ev_reg  <= 1'b0;
      clr_ev_reg <= 1'b0;
      if (start_c || stop_c) begin
        is_write_reg <= 1'b0;
        wr_idx_reg   <= IDX_CMD;
      end
      if (stop_c && is_write_reg && (state_reg == ST_WR)
          && (wr_idx_reg == IDX_FIRST) && !got_byte_reg) begin
        clr_ev_reg <= 1'b1;
      end
      if ((state_reg == ST_ADDR) && fall_c && got_byte_reg
          && addr_hit && (shift_reg[0] != RW_READ)) begin
        is_write_reg <= 1'b1;
      end
      if ((state_reg == ST_WR) && fall_c && got_byte_reg) begin
        wdata_l_reg <= shift_reg;
        widx_l_reg  <= wr_idx_reg;
        wr_idx_reg  <= wr_idx_reg + IDX_STEP;
        if (wr_idx_reg == IDX_CMD) begin
          cmd_ev_reg <= 1'b1;
        end else begin
          wr_ev_reg <= 1'b1;
        end
      end
    end
  end

  // Read-side prefetch: each byte after the first is asked for one byte time ahead; the first during the address acknowledge.
  always_ff @(posedge I_LINK_CLK) begin
    if (!link_rst_n) begin
      rd_idx_reg <= IDX_CMD;
      rd_ev_reg  <= 1'b0;
      rd_buf_reg <= '0;
    end else begin
      rd_ev_reg <= 1'b0;
      if (rd_ack_l) begin
        rd_buf_reg <= rd_data_reg;
      end
      if ((state_reg == ST_ADDR) && fall_c && got_byte_reg
          && addr_hit && (shift_reg[0] == RW_READ)) begin
        rd_idx_reg <= IDX_CMD;
        rd_ev_reg  <= 1'b1;
      end else if (!ara_reg && fall_c && ((state_reg == ST_ADDR_ACK && is_read_reg)
                   || (state_reg == ST_RD_ACK))) begin
        rd_idx_reg <= rd_idx_reg + IDX_STEP;
        rd_ev_reg  <= 1'b1;
      end
    end
  end

  // Open drain data line: only ever pulled low.
  assign O_SDA      = 1'b0;
  assign O_SDA_OE_N = ~sda_low_reg;

  sspa_evt_xing u_cmd_xing (
    .i_src_clk   (I_LINK_CLK),
    .i_src_rst_n (link_rst_n),
    .i_pulse     (cmd_ev_reg),
    .i_dst_clk   (I_REF_CLK),
    .i_dst_rst_n (I_RESET_N),
    .o_pulse     (cmd_r)
  );

  sspa_evt_xing u_wr_xing (
    .i_src_clk   (I_LINK_CLK),
    .i_src_rst_n (link_rst_n),
    .i_pulse     (wr_ev_reg),
    .i_dst_clk   (I_REF_CLK),
    .i_dst_rst_n (I_RESET_N),
    .o_pulse     (wr_r)
  );

  sspa_evt_xing u_rd_xing (
    .i_src_clk   (I_LINK_CLK),
    .i_src_rst_n (link_rst_n),
    .i_pulse     (rd_ev_reg),
    .i_dst_clk   (I_REF_CLK),
    .i_dst_rst_n (I_RESET_N),
    .o_pulse     (rd_r)
  );

  sspa_evt_xing u_clr_xing (
    .i_src_clk   (I_LINK_CLK),
    .i_src_rst_n (link_rst_n),
    .i_pulse     (clr_ev_reg),
    .i_dst_clk   (I_REF_CLK),
    .i_dst_rst_n (I_RESET_N),
    .o_pulse     (clr_r)
  );

  sspa_evt_xing u_ack_xing (
    .i_src_clk   (I_REF_CLK),
    .i_src_rst_n (I_RESET_N),
    .i_pulse     (rd_ack_reg),
    .i_dst_clk   (I_LINK_CLK),
    .i_dst_rst_n (link_rst_n),
    .o_pulse     (rd_ack_l)
  );

  // The link-side bytes hold still for a whole byte time after each
  // event, so sampling them here on the event is safe.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      O_CMD          <= '0;
      O_CMD_VALID    <= 1'b0;
      O_WR_DATA      <= '0;
      O_WR_INDEX     <= '0;
      O_WR_VALID     <= 1'b0;
      O_CLEAR_FAULTS <= 1'b0;
    end else begin
      O_CMD_VALID    <= cmd_r;
      O_WR_VALID     <= wr_r;
      O_CLEAR_FAULTS <= clr_r;
      if (cmd_r) begin
        O_CMD <= wdata_l_reg;
      end
      if (wr_r) begin
        O_WR_DATA  <= wdata_l_reg;
        O_WR_INDEX <= widx_l_reg;
      end
    end
  end

  // Read handshake: data is taken in the request cycle and held until
  // the next request, so the link side may copy it after the ack.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      O_RD_INDEX  <= '0;
      O_RD_REQ    <= 1'b0;
      rd_data_reg <= '0;
      rd_ack_reg  <= 1'b0;
    end else begin
      O_RD_REQ   <= rd_r;
      rd_ack_reg <= O_RD_REQ;
      if (rd_r) begin
        O_RD_INDEX <= rd_idx_reg;
      end
      if (O_RD_REQ) begin
        rd_data_reg <= I_RD_DATA;
      end
    end
  end

  assign alert_byte = I_STATUS_BYTE & ~I_MASK_BYTE & ~NOALERT_BYTE_MASK;
  assign alert_hi   = I_STATUS_WORD_HI & ~I_MASK_WORD_HI & ~NOALERT_HI_MASK;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= (|alert_byte) | (|alert_hi);
    end
  end

  assign O_ALERT      = 1'b0;
  assign O_ALERT_OE_N = ~alert_reg;

endmodule
`default_nettype wire

// file: sim/sspa_properties.sv
/* Port checker for sspa_top, bound to every instance of it.
   Assumes both clocks run and I_RESET_N is the reference-domain reset. */
`timescale 1ns/1ps
`default_nettype none
module sspa_properties #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  input wire logic I_REF_CLK, I_RESET_N, I_LINK_CLK, I_SCL, I_SDA, O_SDA, O_SDA_OE_N,
  input wire logic O_ALERT, O_ALERT_OE_N, O_CMD_VALID, O_WR_VALID, O_CLEAR_FAULTS, O_RD_REQ,
  input wire logic [sspa_pkg::BYTE_W-1:0] I_STATUS_BYTE, I_STATUS_WORD_HI, I_MASK_BYTE,
  input wire logic [sspa_pkg::BYTE_W-1:0] I_MASK_WORD_HI, O_CMD, O_WR_DATA, O_WR_INDEX,
  input wire logic [sspa_pkg::BYTE_W-1:0] O_RD_INDEX, I_RD_DATA
);
  import sspa_pkg::*;
  logic cause;
  // The two fixed status bits never count, whatever the masks say.
  assign cause = (|(I_STATUS_BYTE & ~I_MASK_BYTE & ~NOALERT_BYTE_MASK))
               | (|(I_STATUS_WORD_HI & ~I_MASK_WORD_HI & ~NOALERT_HI_MASK));
  sequence s_scl_high;
    I_SCL ##1 I_SCL;
  endsequence
  sequence s_stop;
    (I_SCL && !I_SDA) ##1 (I_SCL && I_SDA);
  endsequence
  a_alert_follows: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    $past(I_RESET_N) |-> O_ALERT_OE_N == !$past(cause)) else $error("alert level wrong");
  a_alert_quiet: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    !cause [*2] |-> O_ALERT_OE_N) else $error("alert pulled without cause");
  a_alert_open_drain: assert property (@(posedge I_REF_CLK) O_ALERT == 1'b0)
    else $error("alert driven high");
  a_ack_steady: assert property (@(posedge I_LINK_CLK) disable iff (!I_RESET_N)
    s_scl_high |-> $stable(O_SDA_OE_N)) else $error("data line moved while clock high");
  a_stop_released: assert property (@(posedge I_LINK_CLK) disable iff (!I_RESET_N)
    s_stop |=> O_SDA_OE_N [*8]) else $error("data line held after stop");
  a_cmd_single: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_CMD_VALID |=> !O_CMD_VALID [*8]) else $error("command strobe too long");
  a_wr_spaced: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_WR_VALID |=> (!O_WR_VALID && !O_CMD_VALID) [*8]) else $error("write strobes crowd");
  a_clear_alone: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_CLEAR_FAULTS |-> !O_WR_VALID && !O_CMD_VALID ##1 !O_CLEAR_FAULTS)
    else $error("clear strobe malformed");
  a_rdreq_single: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_RD_REQ |=> !O_RD_REQ [*8]) else $error("read request too long");
endmodule
bind sspa_top sspa_properties #(.DEV_ADDR(DEV_ADDR)) props_u (
  .I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_LINK_CLK(I_LINK_CLK), .I_SCL(I_SCL),
  .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE_N(O_SDA_OE_N), .O_ALERT(O_ALERT),
  .O_ALERT_OE_N(O_ALERT_OE_N), .O_CMD_VALID(O_CMD_VALID), .O_WR_VALID(O_WR_VALID),
  .O_CLEAR_FAULTS(O_CLEAR_FAULTS), .O_RD_REQ(O_RD_REQ), .I_STATUS_BYTE(I_STATUS_BYTE),
  .I_STATUS_WORD_HI(I_STATUS_WORD_HI), .I_MASK_BYTE(I_MASK_BYTE),
  .I_MASK_WORD_HI(I_MASK_WORD_HI), .O_CMD(O_CMD), .O_WR_DATA(O_WR_DATA),
  .O_WR_INDEX(O_WR_INDEX), .O_RD_INDEX(O_RD_INDEX), .I_RD_DATA(I_RD_DATA));
`default_nettype wire

// file: sim/sspa_host_model.sv
/* Bus master model that bit-bangs the clock and pulls the data wire.
   Assumes the bench resolves the wire with a pull-up and feeds it back. */
`timescale 1ns/1ps
`default_nettype none
module sspa_host_model (
  output var  logic o_scl,
  output var  logic o_sda_oe_n,
  input  wire logic i_sda
);
  // Half period kept well above sixteen link clocks so the target can follow.
  localparam int HALF = 1000;
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end
  task automatic start();
    o_sda_oe_n = 1'b1;
    #(HALF / 2) o_scl = 1'b1;
    #(HALF / 2) o_sda_oe_n = 1'b0;
    #(HALF / 2) o_scl = 1'b0;
    #(HALF / 2);
  endtask
  task automatic stop();
    o_sda_oe_n = 1'b0;
    #(HALF / 2) o_scl = 1'b1;
    #(HALF / 2) o_sda_oe_n = 1'b1;
    #HALF;
  endtask
  task automatic put_bit(input logic b);
    o_sda_oe_n = b;
    #(HALF / 2) o_scl = 1'b1;
    #HALF o_scl = 1'b0;
    #(HALF / 2);
  endtask
  task automatic get_bit(output logic b);
    o_sda_oe_n = 1'b1;
    #(HALF / 2) o_scl = 1'b1;
    #(HALF / 2) b = i_sda;
    #(HALF / 2) o_scl = 1'b0;
    #(HALF / 2);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(nak);
  endtask
  task automatic get_byte(output logic [7:0] b, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(b[i]);
    put_bit(last);
  endtask
endmodule
`default_nettype wire

// file: sim/sspa_top_tb.sv
/* Bench for sspa_top: the host model works the bus, the bench plays the
   user side and judges strobes, returned bytes and the alert pin. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sspa_top_tb;
  import sspa_pkg::*;
  localparam logic [6:0] DEV = 7'h20;
  logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0;
  logic scl, h_oe_n, d_oe_n, d_sda, sda, al, al_oe_n, cmd_v, wr_v, clr, rd_req;
  logic [7:0] st_b = 8'h00, st_w = 8'h00, mk_b = 8'h00, mk_w = 8'h00, rd_data = 8'h00;
  logic [7:0] cmd, wr_data, wr_idx, rd_idx, b;
  logic [7:0] wq[$], iq[$], rx[$], wbuf[8];
  int fail_count = 0, total_checks = 0, clr_cnt = 0;
  assign sda = h_oe_n & (d_oe_n | d_sda);
  sspa_top #(.DEV_ADDR(DEV)) dut_u (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_LINK_CLK(lclk),
    .I_SCL(scl), .I_SDA(sda), .O_SDA(d_sda), .O_SDA_OE_N(d_oe_n), .O_ALERT(al),
    .O_ALERT_OE_N(al_oe_n), .I_STATUS_BYTE(st_b), .I_STATUS_WORD_HI(st_w),
    .I_MASK_BYTE(mk_b), .I_MASK_WORD_HI(mk_w), .O_CMD(cmd), .O_CMD_VALID(cmd_v),
    .O_WR_DATA(wr_data), .O_WR_INDEX(wr_idx), .O_WR_VALID(wr_v), .O_CLEAR_FAULTS(clr),
    .O_RD_INDEX(rd_idx), .O_RD_REQ(rd_req), .I_RD_DATA(rd_data));
  sspa_host_model host_u (.o_scl(scl), .o_sda_oe_n(h_oe_n), .i_sda(sda));
  initial forever #20 clk = ~clk;
  initial begin
    #7;
    forever #24 lclk = ~lclk;
  end
  function automatic logic [7:0] exp_rd(input logic [7:0] k);
    return (k == 8'h00) ? 8'h02 : (8'ha5 ^ k);
  endfunction
  always @(negedge clk) rd_data <= exp_rd(rd_idx);
  always @(posedge clk) begin
    if (wr_v === 1'b1) begin
      wq.push_back(wr_data);
      iq.push_back(wr_idx);
    end
    if (clr === 1'b1) clr_cnt++;
  end
  task automatic addr(input logic [6:0] a, input logic r, input logic nak_exp);
    logic nak;
    host_u.start();
    host_u.put_byte({a, r}, nak);
    `CHK(nak, nak_exp)
  endtask
  task automatic wr_tr(input logic [7:0] c, input int n, input logic fin);
    logic nak;
    addr(DEV, 1'b0, 1'b0);
    host_u.put_byte(c, nak);
    `CHK(nak, 1'b0)
    for (int i = 0; i < n; i++) begin
      host_u.put_byte(wbuf[i], nak);
      `CHK(nak, 1'b0)
    end
    if (fin) host_u.stop();
    repeat (30) @(negedge clk);
  endtask
  task automatic t_send();
    clr_cnt = 0;
    wr_tr(8'h03, 0, 1'b1);
    `CHK(clr_cnt, 1)
    `CHK(cmd, 8'h03)
    $display("test send_byte done");
  endtask
  task automatic t_write();
    int ns[3] = '{1, 2, 5};
    clr_cnt = 0;
    foreach (ns[j]) begin
      for (int i = 0; i < ns[j]; i++) wbuf[i] = (i == 0 && ns[j] > 2) ? 8'h04 : 8'hc0 + i;
      wq.delete();
      iq.delete();
      wr_tr(8'h20 + ns[j], ns[j], 1'b1);
      `CHK(cmd, 8'h20 + ns[j])
      `CHK(wq.size(), ns[j])
      for (int i = 0; i < wq.size(); i++) begin
        `CHK(wq[i], wbuf[i])
        `CHK(iq[i], i + 1)
      end
    end
    `CHK(clr_cnt, 0)
    $display("test writes done");
  endtask
  task automatic t_read();
    for (int n = 1; n <= 3; n++) begin
      rx.delete();
      wr_tr(8'h8b, 0, 1'b0);
      addr(DEV, 1'b1, 1'b0);
      for (int k = 0; k < n; k++) begin
        host_u.get_byte(b, k == n - 1);
        rx.push_back(b);
      end
      host_u.stop();
      for (int k = 0; k < n; k++) `CHK(rx[k], exp_rd(k))
      `CHK(d_oe_n, 1'b1)
    end
    $display("test reads done");
  endtask
  task automatic t_alert();
    logic [32:0] tab[5] = '{{8'h40, 8'h08, 8'h00, 8'h00, 1'b1}, {8'h01, 8'h00, 8'h01, 8'h00,
      1'b1}, {8'h80, 8'h00, 8'h00, 8'h00, 1'b0}, {8'h00, 8'h10, 8'h00, 8'h10, 1'b1},
      {8'h00, 8'h10, 8'h00, 8'h00, 1'b0}};
    logic e;
    addr(ARA_ADDR, 1'b1, 1'b1);
    host_u.stop();
    addr(7'h21, 1'b0, 1'b1);
    host_u.stop();
    foreach (tab[i]) begin
      @(negedge clk) {st_b, st_w, mk_b, mk_w, e} = tab[i];
      repeat (4) @(negedge clk);
      `CHK(al_oe_n, e)
      `CHK(al, 1'b0)
    end
    addr(ARA_ADDR, 1'b1, 1'b0);
    host_u.get_byte(b, 1'b1);
    host_u.stop();
    `CHK(b, {DEV, ARA_LSB})
    @(negedge clk) st_w = 8'h00;
    repeat (4) @(negedge clk);
    `CHK(al_oe_n, 1'b1)
    $display("test alert done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (10) @(posedge clk);
    t_send();
    t_write();
    t_read();
    t_alert();
    test_done();
  end
  // The whole sequence needs about 0.7 milliseconds of bus time.
  initial begin
    #3000000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
